/* File: inc/psab_pkg.sv */
// Package for the program space address builder.
// Assumes a single core clock domain and a 24-bit program address bus.
package psab_pkg;

   // ----------------------------------------------------------------
   // Widths and field positions
   // ----------------------------------------------------------------
   localparam int PADDR_W   = 24;
   localparam int DADDR_W   = 16;
   localparam int PAGE_W    = 8;
   localparam int PC_W      = 23;
   localparam int VIS_LOW_W = 15;
   localparam int PADDR_MSB = 23;
   localparam int EA_MSB    = 15;
   localparam int PC_LSB    = 1;
   localparam int PAGE_LSB  = 0;

   localparam logic [PAGE_W-1:0]  PAGE_RESET  = 8'h00;
   localparam logic [PADDR_W-1:0] PADDR_RESET = 24'h00_0000;

   // ----------------------------------------------------------------
   // Access types issued by the core
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PSAB_ACC_FETCH,
      PSAB_ACC_TABLE,
      PSAB_ACC_VIS,
      PSAB_ACC_NONE
   } psab_acc_t;

   typedef struct packed
   {
      logic                 valid;
      psab_acc_t            kind;
      logic [PC_W-1:0]      pc;
      logic [DADDR_W-1:0]   effective_addr;
   } psab_req_t;

endpackage

/* File: verilog/psab_builder.sv */
// Program space address builder: forms the 24-bit program address
// for fetches, table accesses and visibility remapping.
// Assumes requests arrive synchronous to clk_sys and page writes are
// one-cycle strobes from the core; the program memory takes the address
// one cycle after the request and may keep using it until the next access.
// A page write and an access may share a cycle; the access sees the old page.
//
// Behaviour
// - Hold 8-bit visibility page value.
// - Join visibility page above low 15 bits.
// - Visibility accesses force address bit 23 low.
// - Fetch uses PC bits 22:1, bit 0 low.
// - Table page placed above full 16-bit address.
// - Visibility address bit 15 comes from page bit 0.
`timescale 1ns/10ps
`default_nettype none

module psab_builder
   import psab_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rstn,
   input  wire psab_req_t         req,
   input  wire logic              vis_page_we,
   input  wire logic              table_page_we,
   input  wire logic [PAGE_W-1:0] page_wdata,
   output logic [PAGE_W-1:0]      visibility_page_value,
   output logic [PAGE_W-1:0]      table_page_value,
   output logic [PADDR_W-1:0]     prog_addr,
   output logic                   prog_addr_valid,
   output logic                   prog_addr_config
);

   // ----------------------------------------------------------------
   // Page registers
   // ----------------------------------------------------------------
   logic [PAGE_W-1:0]  vis_page_reg;
   logic [PAGE_W-1:0]  tbl_page_reg;
   logic [PADDR_W-1:0] addr_reg;
   logic [PADDR_W-1:0] addr_next;
   logic               valid_reg;
   logic [PADDR_W-1:0] fetch_addr;
   logic [PADDR_W-1:0] table_addr;
   logic [PADDR_W-1:0] vis_addr;
   logic               access_take;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         vis_page_reg <= PAGE_RESET;
      else if (vis_page_we)
         vis_page_reg <= page_wdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         tbl_page_reg <= PAGE_RESET;
      else if (table_page_we)
         tbl_page_reg <= page_wdata;
   end

   // ----------------------------------------------------------------
   // Address construction
   // ----------------------------------------------------------------
   // Each source gets its own candidate bus so that the selector below is
   // a plain choice; the price is three address-wide buses instead of one.
   assign fetch_addr  = {1'b0, req.pc[PC_W-1:PC_LSB], 1'b0};
   assign table_addr  = {tbl_page_reg, req.effective_addr};

   // The remap path drops effective address bit 15 because it is always
   // set there; page bit 0 takes its place, so a page spans 32K words of
   // user space, and the top bit is forced low to keep out of configuration space.
   assign vis_addr    = {1'b0, vis_page_reg, req.effective_addr[VIS_LOW_W-1:0]};

   // Only a valid request of a real kind moves the address register.
   assign access_take = req.valid && (req.kind != PSAB_ACC_NONE);

   // ----------------------------------------------------------------
   // Source select
   // ----------------------------------------------------------------
   // The idle code yields zero here, but the register never loads it, so
   // the address seen by the memory stays as the last access left it.
   always_comb
   begin
      addr_next = PADDR_RESET;
      unique case (req.kind)
         PSAB_ACC_FETCH:
            addr_next = fetch_addr;
         PSAB_ACC_TABLE:
            addr_next = table_addr;
         PSAB_ACC_VIS:
            addr_next = vis_addr;
         PSAB_ACC_NONE:
            addr_next = PADDR_RESET;
      endcase
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   // The address is held between accesses so that a slow program memory
   // can keep using it; only the valid flag marks a new access.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         addr_reg <= PADDR_RESET;
      else if (access_take)
         addr_reg <= addr_next;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
         valid_reg <= 1'b0;
      else
         valid_reg <= access_take;
   end

   assign prog_addr             = addr_reg;
   assign prog_addr_valid       = valid_reg;
   assign prog_addr_config      = addr_reg[PADDR_MSB];
   assign visibility_page_value = vis_page_reg;
   assign table_page_value      = tbl_page_reg;

   // ----------------------------------------------------------------
   // Checks: page registers
   // ----------------------------------------------------------------
   // The reset check carries no disable clause on purpose: it must look
   // at exactly the cycles in which reset is applied.
   page_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      vis_page_we |=> vis_page_reg == $past(page_wdata))
      else $error("Visibility page not loaded.");

   page_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !vis_page_we |=> $stable(vis_page_reg))
      else $error("Visibility page changed without a write.");

   tbl_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      table_page_we |=> tbl_page_reg == $past(page_wdata))
      else $error("Table page not loaded.");

   tbl_keep_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !table_page_we |=> $stable(tbl_page_reg))
      else $error("Table page changed without a write.");

   page_reset_a: assert property (@(posedge clk_sys)
      !rstn |=> visibility_page_value == PAGE_RESET && table_page_value == PAGE_RESET)
      else $error("Page registers not cleared by reset.");

   // ----------------------------------------------------------------
   // Checks: address forming
   // ----------------------------------------------------------------
   // The address is registered, so every check looks one cycle back; a page
   // written in the same cycle as the access must not leak into it.
   vis_low_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_VIS
      |=> prog_addr[VIS_LOW_W-1:0] == $past(req.effective_addr[VIS_LOW_W-1:0]))
      else $error("Remap low bits wrong.");

   vis_page_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_VIS
      |=> prog_addr[PADDR_MSB-1:VIS_LOW_W] == $past(vis_page_reg))
      else $error("Remap page bits wrong.");

   vis_top_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_VIS |=> !prog_addr[PADDR_MSB] && prog_addr_valid)
      else $error("Remap reached configuration space.");

   vis_cfg_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_VIS |=> !prog_addr_config)
      else $error("Remap flagged as configuration space.");

   vis_bit15_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_VIS
      |=> prog_addr[EA_MSB] == $past(vis_page_reg[PAGE_LSB]))
      else $error("Remap bit 15 not from page.");

   fetch_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_FETCH
      |=> prog_addr == {1'b0, $past(req.pc[PC_W-1:PC_LSB]), 1'b0})
      else $error("Fetch address wrong.");

   fetch_user_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_FETCH |=> !prog_addr_config && prog_addr_valid)
      else $error("Fetch reached configuration space.");

   table_addr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_TABLE
      |=> prog_addr == {$past(tbl_page_reg), $past(req.effective_addr)})
      else $error("Table address wrong.");

   tbl_space_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind == PSAB_ACC_TABLE
      |=> prog_addr_config == $past(tbl_page_reg[PAGE_W-1]))
      else $error("Table space flag wrong.");

   cfg_source_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      prog_addr_valid && prog_addr_config |-> $past(req.kind) == PSAB_ACC_TABLE)
      else $error("Configuration space reached by a non-table access.");

   // ----------------------------------------------------------------
   // Checks: selection and handshake
   // ----------------------------------------------------------------
   // A refused request must leave the bus exactly as it was, so that a slow
   // memory never sees a change on the address it is still reading.
   source_one_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !req.valid || req.kind == PSAB_ACC_NONE |=> !prog_addr_valid && $stable(prog_addr))
      else $error("Address changed without access.");

   valid_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      req.valid && req.kind != PSAB_ACC_NONE |=> prog_addr_valid)
      else $error("Accepted access not flagged valid.");

   valid_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      prog_addr_valid |-> $past(access_take))
      else $error("Valid flag without an accepted access.");

   addr_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
      !$stable(prog_addr) |-> $past(access_take) || !$past(rstn))
      else $error("Address moved without an access or reset.");

   reset_clear_a: assert property (@(posedge clk_sys)
      !rstn |=> prog_addr == PADDR_RESET && !prog_addr_valid)
      else $error("Address outputs not cleared by reset.");

endmodule

`default_nettype wire

/* File: test/psab_core_model.sv */
// Core model: random accesses and page writes on clk_sys.
// Assumes the builder samples its inputs on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module psab_core_model
   import psab_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         run,
   output psab_req_t         req,
   output logic              vis_we,
   output logic              tbl_we,
   output logic [PAGE_W-1:0] wdata
);
   localparam int REQ_W = $bits(psab_req_t);
   psab_req_t     rnd;
   initial
   begin
      {req, vis_we, tbl_we, wdata} = '0;
      void'($urandom(32'h1039_d5ad));
      forever
      begin
         @(posedge clk_sys);
         rnd = psab_req_t'(REQ_W'({$urandom, $urandom}));
         // The core only remaps when the top address bit is set.
         if (rnd.kind == PSAB_ACC_VIS)
            rnd.effective_addr[EA_MSB] = 1'b1;
         req    <= run ? rnd : '0;
         vis_we <= run & ($urandom_range(3) == 0);
         tbl_we <= run & ($urandom_range(3) == 0);
         wdata  <= 8'($urandom);
      end
   end
endmodule
`default_nettype wire

/* File: test/psab_builder_bench.sv */
// Bench for the address builder: random traffic against a scoreboard.
// Assumes psab_core_model issues every request and page write.
`timescale 1ns/10ps
`default_nettype none
module psab_builder_bench
   import psab_pkg::*;
;
   logic               clk_sys, rstn, run, vis_we, tbl_we, pv, pcfg;
   logic [PAGE_W-1:0]  wdata, vp, tp, vpo, tpo;
   logic [PADDR_W-1:0] pa, e, exp_q[$];
   psab_req_t          req;
   int                 fail_count, comparisons;
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want)
      begin
         fail_count++;
         $display("FAIL at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   psab_core_model core_u (.clk_sys(clk_sys), .run(run), .req(req), .vis_we(vis_we), .tbl_we(tbl_we),
      .wdata(wdata));
   psab_builder dut_u (.clk_sys(clk_sys), .rstn(rstn), .req(req), .vis_page_we(vis_we),
      .table_page_we(tbl_we), .page_wdata(wdata), .visibility_page_value(vpo), .table_page_value(tpo),
      .prog_addr(pa), .prog_addr_valid(pv), .prog_addr_config(pcfg));
   // Expectations use the pages from before this edge: a same-cycle write must not affect the access.
   always @(posedge clk_sys)
   begin
      if (rstn && req.valid === 1'b1 && req.kind != PSAB_ACC_NONE)
      begin
         case (req.kind)
            PSAB_ACC_FETCH: exp_q.push_back({1'b0, req.pc[22:1], 1'b0});
            PSAB_ACC_TABLE: exp_q.push_back({tp, req.effective_addr});
            default:        exp_q.push_back({1'b0, vp, req.effective_addr[14:0]});
         endcase
      end
      vp = !rstn ? '0 : vis_we ? wdata : vp;
      tp = !rstn ? '0 : tbl_we ? wdata : tp;
   end
   always @(negedge clk_sys)
   begin
      if (rstn)
      begin
         chk(32'(pv), 32'(exp_q.size() != 0));
         if (pv === 1'b1 && exp_q.size() != 0)
         begin
            e = exp_q.pop_front();
            chk(32'(pa), 32'(e));
            chk(32'(pcfg), 32'(e[23]));
         end
         else
            chk(32'(pa), 32'(e));
         chk(32'(vpo), 32'(vp));
         chk(32'(tpo), 32'(tp));
      end
      else
         e = PADDR_RESET;
   end
   initial
   begin
      rstn        = 1'b0;
      run         = 1'b0;
      fail_count  = 0;
      comparisons = 0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      run  <= 1'b1;
      repeat (600) @(posedge clk_sys);
      run <= 1'b0;
      repeat (4) @(posedge clk_sys);
      $display("random access test done");
      final_report();
   end
   initial
   begin
      #40000;
      fail_count++;
      final_report();
   end
endmodule
`default_nettype wire
